// *** mpsf_regs.svh ***
/*
 Register offsets, field positions and reset values for the port and flash register bank.
 Assumes inclusion by its bare name from the design files.
*/
`ifndef MPSF_REGS_SVH
`define MPSF_REGS_SVH
`define MPSF_ADDR_PORT0_LATCH      8'h80
`define MPSF_ADDR_PORT1_LATCH      8'h90
`define MPSF_ADDR_PORT1_DIRECTION  8'h91
`define MPSF_ADDR_ERASE_COMMAND    8'h94
`define MPSF_ADDR_EEPROM_DATA      8'h9e
`define MPSF_ADDR_EEPROM_CONTROL   8'h9f
`define MPSF_ADDR_PORT2_LATCH      8'ha0
`define MPSF_ADDR_PORT2_DIRECTION  8'ha1
`define MPSF_ADDR_PORT0_DIRECTION  8'ha2
`define MPSF_ADDR_FLASH_CONTROL    8'hb2
`define MPSF_ADDR_PAGE_SELECT      8'hb7
`define MPSF_ADDR_IRQ_WD_FLAGS     8'he8
`define MPSF_ADDR_EXT_IRQ_INPUTS   8'hf8
`define MPSF_ERASE_PAGE_CODE       8'h55
`define MPSF_ERASE_MASS_CODE       8'haa
`define MPSF_FC_PWE_BIT            0
`define MPSF_FC_MEEN_BIT           1
`define MPSF_FC_SECURE_BIT         6
`define MPSF_FC_PREBOOT_BIT        7
`define MPSF_WDI_XFER_BIT          0
`define MPSF_WDI_WDRST_BIT         7
`define MPSF_RST_PORT0_LATCH       8'hff
`define MPSF_RST_PORT1_LATCH       8'hff
`define MPSF_RST_PORT2_LATCH       8'h00
`define MPSF_RST_DIRECTION         8'h00
`define MPSF_RST_BYTE              8'h00
`define MPSF_RST_PAGE_SELECT       7'h00
`define MPSF_PAGE_LAST             7'h7f
`define MPSF_EXT_IRQ_MASK          8'h7f
`endif

// *** mpsf_pkg.sv ***
/*
 Types shared by the register bank and its port slice.
 Assumes mpsf_regs.svh is on the include path.
*/
package mpsf_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mpsf_sfr_req_t;

  typedef struct packed {
    logic       page_start;
    logic       mass_start;
    logic [6:0] page;
  } mpsf_erase_cmd_t;

  typedef enum logic [1:0] {
    MPSF_FL_IDLE,
    MPSF_FL_PAGE,
    MPSF_FL_MASS
  } mpsf_flash_op_t;
endpackage : mpsf_pkg

// *** mpsf_port.sv ***
/*
 One bidirectional port: latch, direction and pin readback.
 Assumes the core addresses it through the shared register request.
*/
`timescale 1ns/100ps
`include "mpsf_regs.svh"
module mpsf_port #(
  parameter logic [7:0] LATCH_ADDR  = 8'h00,
  parameter logic [7:0] DIR_ADDR    = 8'h00,
  parameter logic [7:0] LATCH_RESET = 8'h00
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire mpsf_pkg::mpsf_sfr_req_t req,
  input  wire logic [7:0]             pin_in,
  output logic [7:0]                  pin_out,
  output logic [7:0]                  pin_oe,
  output logic [7:0]                  pin_level
);
  import mpsf_pkg::*;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_out <= LATCH_RESET;
    end else if (req.wr && req.addr == LATCH_ADDR) begin
      pin_out <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_oe <= `MPSF_RST_DIRECTION;
    end else if (req.wr && req.addr == DIR_ADDR) begin
      pin_oe <= req.wdata;
    end
  end

  // Readback is the pad level, not the latch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_level <= 8'h00;
    end else begin
      pin_level <= pin_in;
    end
  end
endmodule : mpsf_port

// *** mpsf_bank.sv ***
/*
 Special function register bank: digital ports, flash erase and write control,
 security, boot status, serial EEPROM pair, interrupt/watchdog flags and
 external interrupt input view.
 Assumes a single-cycle register request from the core, read data taken one
 cycle after rd, and pin inputs synchronous to sys_clk.
*/
// Behaviour
// - A latch bit of one drives its output pin high, zero drives it low.
// - Direction bit one makes the pin an output, zero an input.
// - Port reads return the real pin level, also for outputs.
// - Port 0 drives pins 4-7, port 1 pins 8-11,14-15, port 2 pins 16-17.
// - Writing 0x55 to erase command starts a page erase of selected page, once per page select write.
// - Writing 0xaa starts mass erase only with enable set and debug port on.
// - Any other erase command value does nothing.
// - Page select holds page 0 to 127, resets to zero.
// - Program write enable steers data-pointer stores into flash, else RAM.
// - Program write enable clears itself after each flash byte written.
// - Program write enable writes are ignored while interrupts are enabled.
// - Write-only mass erase enable gates mass erase, must be set each time.
// - Security bit clears on reset, can be set, ignores writes of zero.
// - Security set blocks external reads of flash and engine program RAM.
// - Boot status bit reads one while the preload sequence runs.
// - Writing the EEPROM control register starts transmission of the data byte.
// - Transfer flag set by the transfer-busy event, cleared by software.
// - Flag bit 7 reads clock-loss flag; write 0 clears, 1 restarts watchdog.
// - External interrupt input register shows inputs 0 to 6 unlatched.
`timescale 1ns/100ps
`include "mpsf_regs.svh"
module mpsf_bank (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire mpsf_pkg::mpsf_sfr_req_t sfr_req,
  output logic [7:0]                   sfr_rdata,
  input  wire logic [13:0]             digital_pin_in,
  output logic [13:0]                  digital_pin_out,
  output logic [13:0]                  digital_pin_oe,
  input  wire logic                    irq_global_enable,
  input  wire logic                    debug_port_enable,
  input  wire logic                    flash_byte_written,
  input  wire logic                    preboot_active,
  input  wire logic                    transfer_busy_event,
  input  wire logic                    clock_loss_event,
  input  wire logic [6:0]              ext_interrupt_levels,
  input  wire logic [7:0]              eeprom_status,
  output mpsf_pkg::mpsf_erase_cmd_t    erase_cmd,
  output logic                         flash_program_write_enable,
  output logic                         security_lock,
  output logic [7:0]                   serial_eeprom_data,
  output logic [7:0]                   serial_eeprom_control,
  output logic                         eeprom_transmit_start,
  output logic                         watchdog_restart,
  output logic                         transfer_irq_flag,
  output logic                         clock_loss_irq_flag
);
  import mpsf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Ports

  logic [7:0] p0_out, p0_oe, p0_lvl;
  logic [7:0] p1_out, p1_oe, p1_lvl;
  logic [7:0] p2_out, p2_oe, p2_lvl;
  logic [7:0] p0_in, p1_in, p2_in;

  // Pin vector index k is pin k+4: 4-7 -> 0-3, 8-11 -> 4-7, 14-15 -> 10-11
  assign p0_in = {4'h0, digital_pin_in[3:0]};
  assign p1_in = {digital_pin_in[11:10], 2'h0, digital_pin_in[7:4]};
  assign p2_in = {6'h00, digital_pin_in[13:12]};

  mpsf_port #(
    .LATCH_ADDR  (`MPSF_ADDR_PORT0_LATCH),
    .DIR_ADDR    (`MPSF_ADDR_PORT0_DIRECTION),
    .LATCH_RESET (`MPSF_RST_PORT0_LATCH)
  ) u_port0 (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .req       (sfr_req),
    .pin_in    (p0_in),
    .pin_out   (p0_out),
    .pin_oe    (p0_oe),
    .pin_level (p0_lvl)
  );

  mpsf_port #(
    .LATCH_ADDR  (`MPSF_ADDR_PORT1_LATCH),
    .DIR_ADDR    (`MPSF_ADDR_PORT1_DIRECTION),
    .LATCH_RESET (`MPSF_RST_PORT1_LATCH)
  ) u_port1 (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .req       (sfr_req),
    .pin_in    (p1_in),
    .pin_out   (p1_out),
    .pin_oe    (p1_oe),
    .pin_level (p1_lvl)
  );

  mpsf_port #(
    .LATCH_ADDR  (`MPSF_ADDR_PORT2_LATCH),
    .DIR_ADDR    (`MPSF_ADDR_PORT2_DIRECTION),
    .LATCH_RESET (`MPSF_RST_PORT2_LATCH)
  ) u_port2 (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .req       (sfr_req),
    .pin_in    (p2_in),
    .pin_out   (p2_out),
    .pin_oe    (p2_oe),
    .pin_level (p2_lvl)
  );

  // Latch and direction regs live in the port slices; outputs are their flops
  // Same index map as the pin inputs; slots 8-9 have no pin and stay low
  assign digital_pin_out = {p2_out[1:0], p1_out[7:6], 2'h0, p1_out[3:0], p0_out[3:0]};
  assign digital_pin_oe  = {p2_oe[1:0], p1_oe[7:6], 2'h0, p1_oe[3:0], p0_oe[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic wr_erase, wr_page, wr_fctl, wr_eed, wr_eec, wr_wdi;

  // One strobe per writable register outside the port slices; unmapped writes raise none
  always_comb begin
    wr_erase = 1'b0;
    wr_page  = 1'b0;
    wr_fctl  = 1'b0;
    wr_eed   = 1'b0;
    wr_eec   = 1'b0;
    wr_wdi   = 1'b0;
    if (sfr_req.wr) begin
      case (sfr_req.addr)
        `MPSF_ADDR_ERASE_COMMAND:  wr_erase = 1'b1;
        `MPSF_ADDR_PAGE_SELECT:    wr_page  = 1'b1;
        `MPSF_ADDR_FLASH_CONTROL:  wr_fctl  = 1'b1;
        `MPSF_ADDR_EEPROM_DATA:    wr_eed   = 1'b1;
        `MPSF_ADDR_EEPROM_CONTROL: wr_eec   = 1'b1;
        `MPSF_ADDR_IRQ_WD_FLAGS:   wr_wdi   = 1'b1;
        default:                   ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash erase

  logic [6:0] page_select_reg;
  logic       page_armed_reg;
  logic       mass_erase_enable_reg;
  logic       page_go, mass_go;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      page_select_reg <= `MPSF_RST_PAGE_SELECT;
    end else if (wr_page) begin
      page_select_reg <= sfr_req.wdata[6:0];
    end
  end

  mpsf_flash_op_t erase_op;

  // Pattern decode; unknown patterns and unmet conditions stay idle
  always_comb begin
    erase_op = MPSF_FL_IDLE;
    if (wr_erase) begin
      case (sfr_req.wdata)
        `MPSF_ERASE_PAGE_CODE: begin
          if (page_armed_reg) begin
            erase_op = MPSF_FL_PAGE;
          end
        end
        `MPSF_ERASE_MASS_CODE: begin
          if (mass_erase_enable_reg && debug_port_enable) begin
            erase_op = MPSF_FL_MASS;
          end
        end
        default: begin
          erase_op = MPSF_FL_IDLE;
        end
      endcase
    end
  end

  assign page_go = erase_op == MPSF_FL_PAGE;
  assign mass_go = erase_op == MPSF_FL_MASS;

  // Arming is consumed by each page erase; a new page write re-arms
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      page_armed_reg <= 1'b0;
    end else if (wr_page) begin
      page_armed_reg <= 1'b1;
    end else if (page_go) begin
      page_armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mass_erase_enable_reg <= 1'b0;
    end else if (wr_fctl) begin
      mass_erase_enable_reg <= sfr_req.wdata[`MPSF_FC_MEEN_BIT];
    end else if (wr_erase && sfr_req.wdata == `MPSF_ERASE_MASS_CODE) begin
      mass_erase_enable_reg <= 1'b0;
    end
  end

  // Other patterns leave both start pulses low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      erase_cmd <= '0;
    end else begin
      erase_cmd.page_start <= page_go;
      erase_cmd.mass_start <= mass_go;
      erase_cmd.page       <= page_select_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash control

  // Interrupt gate first; a blocked write still lets a flash byte clear the bit
  // Security lock is one-way; only chip reset opens it again
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flash_program_write_enable <= 1'b0;
    end else if (wr_fctl && !irq_global_enable) begin
      flash_program_write_enable <= sfr_req.wdata[`MPSF_FC_PWE_BIT];
    end else if (flash_byte_written) begin
      flash_program_write_enable <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      security_lock <= 1'b0;
    end else if (wr_fctl && sfr_req.wdata[`MPSF_FC_SECURE_BIT]) begin
      security_lock <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial EEPROM pair

  // Start pulse follows every control write, whatever code it holds
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serial_eeprom_data <= `MPSF_RST_BYTE;
    end else if (wr_eed) begin
      serial_eeprom_data <= sfr_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serial_eeprom_control <= `MPSF_RST_BYTE;
      eeprom_transmit_start <= 1'b0;
    end else begin
      eeprom_transmit_start <= wr_eec;
      if (wr_eec) begin
        serial_eeprom_control <= sfr_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and watchdog flags; a set beats a same-cycle clear
  // Watchdog restart is one pulse per flag write with bit 7 set

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      transfer_irq_flag <= 1'b0;
    end else if (transfer_busy_event) begin
      transfer_irq_flag <= 1'b1;
    end else if (wr_wdi && !sfr_req.wdata[`MPSF_WDI_XFER_BIT]) begin
      transfer_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clock_loss_irq_flag <= 1'b0;
    end else if (clock_loss_event) begin
      clock_loss_irq_flag <= 1'b1;
    end else if (wr_wdi && !sfr_req.wdata[`MPSF_WDI_WDRST_BIT]) begin
      clock_loss_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      watchdog_restart <= 1'b0;
    end else begin
      watchdog_restart <= wr_wdi && sfr_req.wdata[`MPSF_WDI_WDRST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Read data holds between reads; ports read their pads, not latches
  logic [7:0] rd_next;
  logic [7:0] fctl_view;

  always_comb begin
    fctl_view = 8'h00;
    fctl_view[`MPSF_FC_PWE_BIT]     = flash_program_write_enable;
    fctl_view[`MPSF_FC_SECURE_BIT]  = security_lock;
    fctl_view[`MPSF_FC_PREBOOT_BIT] = preboot_active;
  end

  always_comb begin
    case (sfr_req.addr)
      `MPSF_ADDR_PORT0_LATCH:     rd_next = p0_lvl;
      `MPSF_ADDR_PORT1_LATCH:     rd_next = p1_lvl;
      `MPSF_ADDR_PORT2_LATCH:     rd_next = p2_lvl;
      `MPSF_ADDR_PORT0_DIRECTION: rd_next = p0_oe;
      `MPSF_ADDR_PORT1_DIRECTION: rd_next = p1_oe;
      `MPSF_ADDR_PORT2_DIRECTION: rd_next = p2_oe;
      `MPSF_ADDR_PAGE_SELECT:     rd_next = {1'b0, page_select_reg};
      `MPSF_ADDR_FLASH_CONTROL:   rd_next = fctl_view;
      `MPSF_ADDR_EEPROM_DATA:     rd_next = serial_eeprom_data;
      `MPSF_ADDR_EEPROM_CONTROL:  rd_next = eeprom_status;
      `MPSF_ADDR_IRQ_WD_FLAGS:    rd_next = {clock_loss_irq_flag, 6'h00, transfer_irq_flag};
      `MPSF_ADDR_EXT_IRQ_INPUTS:  rd_next = {1'b0, ext_interrupt_levels};
      default:                    rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_req.rd) begin
      sfr_rdata <= rd_next;
    end
  end
endmodule : mpsf_bank

// *** mpsf_bank_sva.sv ***
/*
 Concurrent checks on the port and flash register bank, seen from its ports.
 Assumes mpsf_pkg is compiled first and a bind from the bench top file.
*/
`timescale 1ns/100ps
module mpsf_bank_chk (
  input wire logic                      sys_clk,
  input wire logic                      rst_n,
  input wire mpsf_pkg::mpsf_sfr_req_t   sfr_req,
  input wire logic [7:0]                sfr_rdata,
  input wire logic                      irq_global_enable,
  input wire logic                      debug_port_enable,
  input wire logic                      flash_byte_written,
  input wire logic                      preboot_active,
  input wire logic                      transfer_busy_event,
  input wire logic                      clock_loss_event,
  input wire logic [6:0]                ext_interrupt_levels,
  input wire mpsf_pkg::mpsf_erase_cmd_t erase_cmd,
  input wire logic                      flash_program_write_enable,
  input wire logic                      security_lock,
  input wire logic                      eeprom_transmit_start,
  input wire logic                      watchdog_restart,
  input wire logic                      transfer_irq_flag,
  input wire logic                      clock_loss_irq_flag
);
  import mpsf_pkg::*;
  logic wr_erase;
  assign wr_erase = sfr_req.wr && sfr_req.addr == 8'h94;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  property p_page_start;
    erase_cmd.page_start |-> $past(wr_erase && sfr_req.wdata == 8'h55);
  endproperty
  a_page_start: assert property (p_page_start) else $error("page erase without command");
  property p_mass_start;
    erase_cmd.mass_start |-> $past(wr_erase && sfr_req.wdata == 8'haa && debug_port_enable);
  endproperty
  a_mass_start: assert property (p_mass_start) else $error("mass erase without command");
  property p_bad_pattern;
    wr_erase && !(sfr_req.wdata inside {8'h55, 8'haa}) |=> !erase_cmd.page_start && !erase_cmd.mass_start;
  endproperty
  a_bad_pattern: assert property (p_bad_pattern) else $error("erase started by other pattern");
  property p_pwe_block;
    irq_global_enable && !flash_program_write_enable |=> !flash_program_write_enable;
  endproperty
  a_pwe_block: assert property (p_pwe_block) else $error("write enable set with interrupts on");
  property p_pwe_clear;
    flash_byte_written && !sfr_req.wr |=> !flash_program_write_enable;
  endproperty
  a_pwe_clear: assert property (p_pwe_clear) else $error("write enable kept after byte");
  property p_secure_hold;
    security_lock |=> security_lock [*3];
  endproperty
  a_secure_hold: assert property (p_secure_hold) else $error("security lock cleared");
  property p_ee_start;
    sfr_req.wr && sfr_req.addr == 8'h9f |=> eeprom_transmit_start;
  endproperty
  a_ee_start: assert property (p_ee_start) else $error("no transmit start");
  property p_xfer_set;
    transfer_busy_event |=> transfer_irq_flag;
  endproperty
  a_xfer_set: assert property (p_xfer_set) else $error("transfer flag not set");
  property p_clk_loss;
    clock_loss_event |=> clock_loss_irq_flag;
  endproperty
  a_clk_loss: assert property (p_clk_loss) else $error("clock loss flag not set");
  property p_wd_restart;
    sfr_req.wr && sfr_req.addr == 8'he8 |=> watchdog_restart == $past(sfr_req.wdata[7]);
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("watchdog restart wrong");
  property p_ext_read;
    sfr_req.rd && sfr_req.addr == 8'hf8 |=> sfr_rdata == {1'b0, $past(ext_interrupt_levels)};
  endproperty
  a_ext_read: assert property (p_ext_read) else $error("interrupt input read wrong");
  property p_boot_read;
    sfr_req.rd && sfr_req.addr == 8'hb2 |=> sfr_rdata[7] == $past(preboot_active);
  endproperty
  a_boot_read: assert property (p_boot_read) else $error("boot status read wrong");
  c_page: cover property (erase_cmd.page_start);
  c_mass: cover property (erase_cmd.mass_start);
  c_ee: cover property (eeprom_transmit_start);
endmodule : mpsf_bank_chk

// *** tb_top.sv ***
/*
 Directed self-checking bench for the port and flash register bank.
 Assumes mpsf_pkg, the bank design and its checker are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  import mpsf_pkg::*;
  logic            sys_clk = 1'b0;
  logic            rst_n = 1'b0;
  mpsf_sfr_req_t   sfr_req = '0;
  logic [7:0]      sfr_rdata, serial_eeprom_data, serial_eeprom_control;
  logic [13:0]     digital_pin_in = '0;
  logic [13:0]     digital_pin_out, digital_pin_oe;
  logic            irq_global_enable = 0, debug_port_enable = 0, flash_byte_written = 0, preboot_active = 0;
  logic            transfer_busy_event = 0, clock_loss_event = 0;
  logic [6:0]      ext_interrupt_levels = '0;
  logic [7:0]      eeprom_status = '0;
  mpsf_erase_cmd_t erase_cmd, last_cmd;
  logic            flash_program_write_enable, security_lock, eeprom_transmit_start, watchdog_restart;
  logic            transfer_irq_flag, clock_loss_irq_flag, last_ee, last_wd;
  int              err_total = 0, check_count = 0, cycles = 0;
  logic [7:0]      bad_codes [4] = '{8'h00, 8'h54, 8'hab, 8'hff};

  mpsf_bank i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .digital_pin_in(digital_pin_in), .digital_pin_out(digital_pin_out), .digital_pin_oe(digital_pin_oe),
    .irq_global_enable(irq_global_enable), .debug_port_enable(debug_port_enable),
    .flash_byte_written(flash_byte_written), .preboot_active(preboot_active),
    .transfer_busy_event(transfer_busy_event), .clock_loss_event(clock_loss_event),
    .ext_interrupt_levels(ext_interrupt_levels), .eeprom_status(eeprom_status), .erase_cmd(erase_cmd),
    .flash_program_write_enable(flash_program_write_enable), .security_lock(security_lock),
    .serial_eeprom_data(serial_eeprom_data), .serial_eeprom_control(serial_eeprom_control),
    .eeprom_transmit_start(eeprom_transmit_start), .watchdog_restart(watchdog_restart),
    .transfer_irq_flag(transfer_irq_flag), .clock_loss_irq_flag(clock_loss_irq_flag));

  always #2.5 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // Write, keeping the one-cycle pulses for later checks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{1'b1, 1'b0, a, d};
    tick(1);
    sfr_req = '0;
    last_cmd = erase_cmd;
    last_ee = eeprom_transmit_start;
    last_wd = watchdog_restart;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    sfr_req = '{1'b0, 1'b1, a, 8'h00};
    tick(1);
    sfr_req = '0;
    chk(14'(sfr_rdata & m), 14'(exp & m));
    tick(1);
  endtask : rd
  task automatic ers(input logic [7:0] d, input logic [1:0] exp);
    wr(8'h94, d);
    chk(14'({last_cmd.page_start, last_cmd.mass_start}), 14'(exp));
  endtask : ers
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(digital_pin_oe, 14'h0);
    chk(digital_pin_out, 14'h0cff);
    chk(14'({flash_program_write_enable, security_lock, transfer_irq_flag}), 14'h0);
    rd(8'hb7, 8'h00, 8'h7f);
    rd(8'h81, 8'h00, 8'hff);
  endtask : t_reset
  task automatic t_ports;
    wr(8'ha2, 8'h0f);
    wr(8'h80, 8'h05);
    chk(14'(digital_pin_oe[3:0]), 14'hf);
    chk(14'(digital_pin_out[3:0]), 14'h5);
    digital_pin_in = 14'h000a;
    tick(2);
    rd(8'h80, 8'h0a, 8'h0f);
    wr(8'ha2, 8'h00);
    chk(14'(digital_pin_oe[3:0]), 14'h0);
    wr(8'h91, 8'hcf);
    wr(8'h90, 8'h8a);
    wr(8'ha1, 8'h03);
    wr(8'ha0, 8'h02);
    chk(digital_pin_oe, 14'h3cf0);
    chk(digital_pin_out, 14'h28a5);
    digital_pin_in = 14'h2f50;
    tick(2);
    rd(8'h90, 8'hc5, 8'hff);
    rd(8'ha0, 8'h02, 8'hff);
    rd(8'h91, 8'hcf, 8'hff);
  endtask : t_ports
  task automatic t_erase;
    ers(8'h55, 2'b00);
    wr(8'hb7, 8'h05);
    ers(8'h55, 2'b10);
    chk(14'(last_cmd.page), 14'h5);
    ers(8'h55, 2'b00);
    wr(8'hb7, 8'h7f);
    ers(8'h55, 2'b10);
    chk(14'(last_cmd.page), 14'h7f);
    wr(8'hb7, 8'h01);
    foreach (bad_codes[i]) ers(bad_codes[i], 2'b00);
    ers(8'haa, 2'b00);
    debug_port_enable = 1'b1;
    wr(8'hb2, 8'h02);
    ers(8'haa, 2'b01);
    ers(8'haa, 2'b00);
    debug_port_enable = 1'b0;
    wr(8'hb2, 8'h02);
    ers(8'haa, 2'b00);
  endtask : t_erase
  task automatic t_flash;
    irq_global_enable = 1'b1;
    wr(8'hb2, 8'h01);
    chk(14'(flash_program_write_enable), 14'h0);
    irq_global_enable = 1'b0;
    wr(8'hb2, 8'h01);
    chk(14'(flash_program_write_enable), 14'h1);
    rd(8'hb2, 8'h01, 8'h01);
    flash_byte_written = 1'b1;
    tick(1);
    flash_byte_written = 1'b0;
    tick(1);
    chk(14'(flash_program_write_enable), 14'h0);
    wr(8'hb2, 8'h40);
    wr(8'hb2, 8'h00);
    chk(14'(security_lock), 14'h1);
    preboot_active = 1'b1;
    tick(1);
    rd(8'hb2, 8'hc0, 8'hc0);
    preboot_active = 1'b0;
    tick(1);
    rd(8'hb2, 8'h00, 8'h80);
  endtask : t_flash
  task automatic t_ee_flags;
    wr(8'h9e, 8'h3c);
    wr(8'h9f, 8'h05);
    chk(14'(last_ee), 14'h1);
    chk(14'(serial_eeprom_data), 14'h3c);
    chk(14'(serial_eeprom_control), 14'h05);
    eeprom_status = 8'h81;
    tick(1);
    rd(8'h9f, 8'h81, 8'hff);
    transfer_busy_event = 1'b1;
    clock_loss_event = 1'b1;
    tick(1);
    transfer_busy_event = 1'b0;
    clock_loss_event = 1'b0;
    chk(14'({clock_loss_irq_flag, transfer_irq_flag}), 14'h3);
    rd(8'he8, 8'h81, 8'h81);
    wr(8'he8, 8'hfe);
    chk(14'({clock_loss_irq_flag, transfer_irq_flag, last_wd}), 14'h5);
    wr(8'he8, 8'h7f);
    chk(14'({clock_loss_irq_flag, last_wd}), 14'h0);
    foreach (bad_codes[i]) begin
      ext_interrupt_levels = bad_codes[i][6:0];
      tick(1);
      rd(8'hf8, {1'b0, bad_codes[i][6:0]}, 8'hff);
    end
  endtask : t_ee_flags
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_ports();
    t_erase();
    t_flash();
    t_ee_flags();
    print_verdict();
  end
endmodule : tb_top

bind mpsf_bank mpsf_bank_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .irq_global_enable(irq_global_enable), .debug_port_enable(debug_port_enable),
  .flash_byte_written(flash_byte_written), .preboot_active(preboot_active),
  .transfer_busy_event(transfer_busy_event), .clock_loss_event(clock_loss_event),
  .ext_interrupt_levels(ext_interrupt_levels), .erase_cmd(erase_cmd),
  .flash_program_write_enable(flash_program_write_enable), .security_lock(security_lock),
  .eeprom_transmit_start(eeprom_transmit_start), .watchdog_restart(watchdog_restart),
  .transfer_irq_flag(transfer_irq_flag), .clock_loss_irq_flag(clock_loss_irq_flag));
